// [pcs_map.vh]
// Register offsets, field positions, reset values and operation codes of the sequencer.
`ifndef PCS_MAP_VH
`define PCS_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define PCS_IDX_INDIRECT 6'h00
`define PCS_IDX_PC 6'h02
`define PCS_IDX_STATUS 6'h03
`define PCS_IDX_RAM_SEL 6'h04
`define PCS_IDX_PC_STATE 6'h08
`define PCS_IDX_W 6

// Field positions.
`define PCS_STATUS_PAGE_LSB 5
`define PCS_STATUS_PAGE_MSB 7
`define PCS_RAM_SEL_PTR_MSB 5
`define PCS_STATE_DEPTH_LSB 8
`define PCS_STATE_DEPTH_MSB 11
`define PCS_PC_LOW_MSB 7
`define PCS_PC_KEEP_MSB 9
`define PCS_PC_PAGE_LSB 10

// Reset values.
`define PCS_PC_RST 13'h0000
`define PCS_PAGE_RST 3'h0
`define PCS_RAM_SEL_RST 8'h00

// Page select: codes above the last page fold onto it for the program counter only.
`define PCS_LAST_PAGE 3'h5

// Operation codes from the instruction decoder.
`define PCS_OP_STEP 3'h0
`define PCS_OP_JUMP 3'h1
`define PCS_OP_CALL 3'h2
`define PCS_OP_RET 3'h3
`define PCS_OP_RET_LIT 3'h4
`define PCS_OP_RET_INT 3'h5
`define PCS_OP_ADD_PC 3'h6
`define PCS_OP_MOV_PC 3'h7

// Bus constants.
`define PCS_HTRANS_NONSEQ_BIT 1
`define PCS_HRESP_OKAY 1'h0

`endif

// [pcs_sequencer.v]
// Program counter sequencer with return stack, indirect address redirect and AHB-Lite registers.
//
// Register access over AHB-Lite is this design's own decision.

`include "pcs_map.vh"

module pcs_sequencer #(
  parameter PC_W = 13,
  parameter TGT_W = 10,
  parameter STACK_DEPTH = 8,
  parameter PTR_W = 3,
  parameter DEPTH_W = 4
) (
  // Clock and reset
  input wire REF_CLK_IN,
  input wire NRST_IN,
  // AHB-Lite slave
  input wire HSEL_IN,
  input wire [31:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire HWRITE_IN,
  input wire [2:0] HSIZE_IN,
  input wire [31:0] HWDATA_IN,
  input wire HREADY_IN,
  output wire [31:0] HRDATA_OUT,
  output wire HREADYOUT_OUT,
  output wire HRESP_OUT,
  // Instruction decoder
  input wire OP_VALID_IN,
  input wire [2:0] OP_KIND_IN,
  input wire [TGT_W-1:0] OP_TARGET_IN,
  input wire [7:0] ACC_IN,
  input wire [5:0] OPERAND_ADDR_IN,
  // Program fetch and data addressing
  output wire [PC_W-1:0] FETCH_ADDR_OUT,
  output wire [5:0] EFF_ADDR_OUT,
  output wire [7:0] RAM_SEL_PTR_OUT,
  output wire [2:0] PAGE_SEL_OUT,
  output wire [DEPTH_W-1:0] STACK_LEVEL_OUT
);

  reg [PC_W-1:0] pc_ff;
  reg [PC_W-1:0] nxt_pc;
  reg [2:0] page_ff;
  reg [2:0] nxt_page;
  reg [7:0] ram_sel_ff;
  reg [7:0] nxt_ram_sel;
  reg [PTR_W-1:0] sp_ff;
  reg [PTR_W-1:0] nxt_sp;
  reg [DEPTH_W-1:0] depth_ff;
  reg [DEPTH_W-1:0] nxt_depth;
  reg [5:0] eff_addr_ff;
  reg [PC_W-1:0] stack_ff [0:STACK_DEPTH-1];

  reg wr_pend_ff;
  reg [`PCS_IDX_W-1:0] wr_idx_ff;
  reg [31:0] hrdata_ff;
  reg [31:0] nxt_hrdata;

  wire addr_ok;
  wire bus_take;
  wire [`PCS_IDX_W-1:0] rd_idx;
  wire [`PCS_IDX_W-1:0] wr_target;
  wire [2:0] page_eff;
  wire [PC_W-1:0] pc_inc;
  wire [PC_W-1:0] pc_mov;
  wire [PC_W-1:0] stack_top;
  wire push;
  wire pop;
  wire bus_pc_wr;
  wire [7:0] wr_byte;

  // The slave never inserts wait states, so the data phase always completes at once.
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = `PCS_HRESP_OKAY;
  assign HRDATA_OUT = hrdata_ff;

  // Only the low byte of the word is meaningful, except depth in bits 11:8 of the state register; upper address bits must be zero to hit.
  assign addr_ok = (HADDR_IN[31:8] == 24'h000000);
  assign bus_take = HSEL_IN & HTRANS_IN[`PCS_HTRANS_NONSEQ_BIT] & HREADY_IN;
  assign rd_idx = HADDR_IN[7:2];
  assign wr_byte = HWDATA_IN[7:0];

  // Index zero is a window onto the register the pointer selects.
  assign wr_target = (wr_idx_ff == `PCS_IDX_INDIRECT) ?
                     ram_sel_ff[`PCS_RAM_SEL_PTR_MSB:0] : wr_idx_ff;

  // Codes six and seven fold onto the last page.
  assign page_eff = (page_ff > `PCS_LAST_PAGE) ? `PCS_LAST_PAGE : page_ff;

  // The increment ignores the page fold, so stepping or adding past 6143, the last word of page five, reaches higher addresses.
  assign pc_inc = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};

  assign pc_mov = {page_eff, pc_ff[`PCS_PC_KEEP_MSB:`PCS_PC_LOW_MSB+1], wr_byte};

  assign stack_top = stack_ff[sp_ff - {{(PTR_W-1){1'b0}}, 1'b1}];

  assign push = OP_VALID_IN & (OP_KIND_IN == `PCS_OP_CALL);
  assign pop = OP_VALID_IN & ((OP_KIND_IN == `PCS_OP_RET) |
                              (OP_KIND_IN == `PCS_OP_RET_LIT) |
                              (OP_KIND_IN == `PCS_OP_RET_INT));

  assign bus_pc_wr = wr_pend_ff & (wr_target == `PCS_IDX_PC);

  // Next program counter. A bus write to the counter register wins over the decoder
  // in the same cycle, because software expects its store to land.
  always @* begin
    nxt_pc = pc_ff;
    if (bus_pc_wr) begin
      nxt_pc = pc_mov;
    end else if (OP_VALID_IN) begin
      case (OP_KIND_IN)
        `PCS_OP_JUMP: begin
          nxt_pc = {page_eff, OP_TARGET_IN};
        end
        `PCS_OP_CALL: begin
          nxt_pc = {page_eff, OP_TARGET_IN};
        end
        `PCS_OP_RET, `PCS_OP_RET_LIT, `PCS_OP_RET_INT: begin
          nxt_pc = stack_top;
        end
        `PCS_OP_ADD_PC: begin
          nxt_pc = pc_inc + {{(PC_W-8){1'b0}}, ACC_IN};
        end
        `PCS_OP_MOV_PC: begin
          nxt_pc = {page_eff, pc_ff[`PCS_PC_KEEP_MSB:`PCS_PC_LOW_MSB+1], ACC_IN};
        end
        default: begin
          nxt_pc = pc_inc;
        end
      endcase
    end
  end

  // Page and pointer change only by software; returns never touch the page.
  always @* begin
    nxt_page = page_ff;
    nxt_ram_sel = ram_sel_ff;
    if (wr_pend_ff) begin
      case (wr_target)
        `PCS_IDX_STATUS: begin
          nxt_page = wr_byte[`PCS_STATUS_PAGE_MSB:`PCS_STATUS_PAGE_LSB];
        end
        `PCS_IDX_RAM_SEL: begin
          nxt_ram_sel = wr_byte;
        end
        default: begin
          nxt_page = page_ff;
        end
      endcase
    end
  end

  // Stack pointer wraps, so a ninth nested call overwrites the oldest entry.
  always @* begin
    nxt_sp = sp_ff;
    nxt_depth = depth_ff;
    if (push) begin
      nxt_sp = sp_ff + {{(PTR_W-1){1'b0}}, 1'b1};
      if (depth_ff != STACK_DEPTH[DEPTH_W-1:0]) begin
        nxt_depth = depth_ff + {{(DEPTH_W-1){1'b0}}, 1'b1};
      end
    end else if (pop) begin
      nxt_sp = sp_ff - {{(PTR_W-1){1'b0}}, 1'b1};
      if (depth_ff != {DEPTH_W{1'b0}}) begin
        nxt_depth = depth_ff - {{(DEPTH_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Reads return the value the register holds after this cycle's update, so a read
  // straight behind a write sees the written value.
  function [7:0] reg_byte;
    input [`PCS_IDX_W-1:0] idx;
    input [PC_W-1:0] pc_v;
    input [2:0] page_v;
    input [7:0] sel_v;
    begin
      case (idx)
        `PCS_IDX_PC: begin
          reg_byte = pc_v[`PCS_PC_LOW_MSB:0];
        end
        `PCS_IDX_STATUS: begin
          reg_byte = {page_v, 5'h00};
        end
        `PCS_IDX_RAM_SEL: begin
          reg_byte = sel_v;
        end
        default: begin
          reg_byte = 8'h00;
        end
      endcase
    end
  endfunction

  always @* begin
    nxt_hrdata = 32'h00000000;
    if (bus_take & ~HWRITE_IN & addr_ok) begin
      case (rd_idx)
        `PCS_IDX_INDIRECT: begin
          nxt_hrdata = {24'h000000, reg_byte(nxt_ram_sel[`PCS_RAM_SEL_PTR_MSB:0],
                                             nxt_pc, nxt_page, nxt_ram_sel)};
        end
        `PCS_IDX_PC_STATE: begin
          nxt_hrdata = {20'h00000, nxt_depth, 3'h0, nxt_pc[PC_W-1:`PCS_PC_LOW_MSB+1]};
        end
        default: begin
          nxt_hrdata = {24'h000000, reg_byte(rd_idx, nxt_pc, nxt_page, nxt_ram_sel)};
        end
      endcase
    end
  end

  always @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      pc_ff <= `PCS_PC_RST;
      page_ff <= `PCS_PAGE_RST;
      ram_sel_ff <= `PCS_RAM_SEL_RST;
      sp_ff <= {PTR_W{1'b0}};
      depth_ff <= {DEPTH_W{1'b0}};
      eff_addr_ff <= 6'h00;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= {`PCS_IDX_W{1'b0}};
      hrdata_ff <= 32'h00000000;
    end else begin
      pc_ff <= nxt_pc;
      page_ff <= nxt_page;
      ram_sel_ff <= nxt_ram_sel;
      sp_ff <= nxt_sp;
      depth_ff <= nxt_depth;
      // Operand zero is resolved through the pointer as it stands after this cycle.
      if (OPERAND_ADDR_IN == 6'h00) begin
        eff_addr_ff <= nxt_ram_sel[`PCS_RAM_SEL_PTR_MSB:0];
      end else begin
        eff_addr_ff <= OPERAND_ADDR_IN;
      end
      wr_pend_ff <= bus_take & HWRITE_IN & addr_ok;
      wr_idx_ff <= rd_idx;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // The stack array holds data only, so it carries no reset.
  always @(posedge REF_CLK_IN) begin
    if (NRST_IN && push) begin
      stack_ff[sp_ff] <= pc_inc;
    end
  end

  assign FETCH_ADDR_OUT = pc_ff;
  assign EFF_ADDR_OUT = eff_addr_ff;
  assign RAM_SEL_PTR_OUT = ram_sel_ff;
  assign PAGE_SEL_OUT = page_ff;
  assign STACK_LEVEL_OUT = depth_ff;

endmodule

// [pcs_chk.sv]
// Port-level assertion checker for the program counter sequencer.
module pcs_chk #(
  parameter STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // Register bus
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  // Decoder
  input wire logic OP_VALID_IN,
  input wire logic [2:0] OP_KIND_IN,
  input wire logic [9:0] OP_TARGET_IN,
  input wire logic [7:0] ACC_IN,
  input wire logic [5:0] OPERAND_ADDR_IN,
  // State
  input wire logic [12:0] FETCH_ADDR_OUT,
  input wire logic [5:0] EFF_ADDR_OUT,
  input wire logic [7:0] RAM_SEL_PTR_OUT,
  input wire logic [2:0] PAGE_SEL_OUT,
  input wire logic [3:0] STACK_LEVEL_OUT
);
  logic pcw_ff;
  wire [2:0] k = OP_KIND_IN;
  wire [12:0] f = FETCH_ADDR_OUT;
  wire [3:0] l = STACK_LEVEL_OUT;
  wire [2:0] pg = (PAGE_SEL_OUT > 3'h5) ? 3'h5 : PAGE_SEL_OUT;
  // A bus write to the counter overrides an op in its data phase; cycles after a direct write to address 8 are skipped.
  wire v = OP_VALID_IN & ~pcw_ff;
  always @(posedge REF_CLK_IN) begin
    pcw_ff <= NRST_IN & HSEL_IN & HTRANS_IN[1] & HWRITE_IN & (HADDR_IN == 32'h8);
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  property p_step; v && k == 3'h0 |=> f == $past(f) + 13'h1; endproperty
  property p_jump; v && k == 3'h1 |=> f == {$past(pg), $past(OP_TARGET_IN)}; endproperty
  property p_call;
    v && k == 3'h2 |=> f == {$past(pg), $past(OP_TARGET_IN)} &&
      l == ($past(l) == STACK_DEPTH ? $past(l) : $past(l) + 4'h1);
  endproperty
  property p_ret;
    v && k == 3'h2 ##1 v && k inside {[3'h3:3'h5]} |=> f == $past(f, 2) + 13'h1;
  endproperty
  property p_add; v && k == 3'h6 |=> f == $past(f) + 13'h1 + {5'h0, $past(ACC_IN)}; endproperty
  property p_mov; v && k == 3'h7 |=> f == {$past(pg), $past(f[9:8]), $past(ACC_IN)}; endproperty
  property p_eff;
    1'b1 |=> EFF_ADDR_OUT == ($past(OPERAND_ADDR_IN) == 6'h0 ?
      RAM_SEL_PTR_OUT[5:0] : $past(OPERAND_ADDR_IN));
  endproperty
  property p_rst; disable iff (1'b0) !NRST_IN |=> f == 13'h0 && l == 4'h0; endproperty
  a_step: assert property (p_step) else $error("counter did not advance");
  a_jump: assert property (p_jump) else $error("jump target wrong");
  a_call: assert property (p_call) else $error("call wrong");
  a_ret: assert property (p_ret) else $error("return address wrong");
  a_add: assert property (p_add) else $error("relative add wrong");
  a_mov: assert property (p_mov) else $error("move to counter wrong");
  a_eff: assert property (p_eff) else $error("operand address wrong");
  a_rst: assert property (p_rst) else $error("reset left counter set");
  c_call: cover property (v && k == 3'h2 ##1 v && k == 3'h3);
  c_fold: cover property (v && k == 3'h1 && PAGE_SEL_OUT == 3'h7);
  c_ind: cover property (OPERAND_ADDR_IN == 6'h0 && RAM_SEL_PTR_OUT != 8'h0);
endmodule

bind pcs_sequencer pcs_chk #(.STACK_DEPTH(STACK_DEPTH)) pcs_chk_inst (
  .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
  .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .OP_VALID_IN(OP_VALID_IN),
  .OP_KIND_IN(OP_KIND_IN), .OP_TARGET_IN(OP_TARGET_IN), .ACC_IN(ACC_IN),
  .OPERAND_ADDR_IN(OPERAND_ADDR_IN), .FETCH_ADDR_OUT(FETCH_ADDR_OUT),
  .EFF_ADDR_OUT(EFF_ADDR_OUT), .RAM_SEL_PTR_OUT(RAM_SEL_PTR_OUT),
  .PAGE_SEL_OUT(PAGE_SEL_OUT), .STACK_LEVEL_OUT(STACK_LEVEL_OUT));

// [pcs_dec_model.sv]
// Instruction decoder stand-in that issues one executed instruction per call.
module pcs_dec_model (
  // Clock
  input wire logic clk_in,
  // Decoder outputs
  output logic vld_out,
  output logic [2:0] kind_out,
  output logic [9:0] tgt_out,
  output logic [7:0] acc_out,
  output logic [5:0] opa_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {vld_out, kind_out, tgt_out, acc_out, opa_out} = 28'h0;
  end
  task automatic op(input logic [2:0] k, input logic [9:0] t, input logic [7:0] a,
                    input logic [5:0] d);
    {vld_out, kind_out, tgt_out, acc_out, opa_out} <= {1'b1, k, t, a, d};
    @(posedge clk_in);
    // Stale target and accumulator fields are inverted; kind and operand address keep their values.
    {vld_out, tgt_out, acc_out} <= {1'b0, ~t, ~a};
  endtask
endmodule

// [program_counter_sequencer_tb_top.sv]
// Self-checking bench for the program counter sequencer.
module program_counter_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, hw;
  logic [1:0] htr;
  logic [31:0] ha, hwd, q, hrd;
  logic hro, vld, hrs;
  logic [2:0] kind, pg;
  logic [9:0] tgt;
  logic [7:0] acc, ptr;
  logic [5:0] opa, eff;
  logic [12:0] fa, pc;
  logic [3:0] lvl;
  logic [12:0] st[$];
  int bad_count, n_tests;
  pcs_sequencer pcs_sequencer_inst (.REF_CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(1'b1),
    .HADDR_IN(ha), .HTRANS_IN(htr), .HWRITE_IN(hw), .HSIZE_IN(3'h2), .HWDATA_IN(hwd),
    .HREADY_IN(hro), .HRDATA_OUT(hrd), .HREADYOUT_OUT(hro), .HRESP_OUT(hrs),
    .OP_VALID_IN(vld), .OP_KIND_IN(kind), .OP_TARGET_IN(tgt), .ACC_IN(acc),
    .OPERAND_ADDR_IN(opa), .FETCH_ADDR_OUT(fa), .EFF_ADDR_OUT(eff),
    .RAM_SEL_PTR_OUT(ptr), .PAGE_SEL_OUT(pg), .STACK_LEVEL_OUT(lvl));
  pcs_dec_model pcs_dec_model_inst (.clk_in(clk), .vld_out(vld), .kind_out(kind),
    .tgt_out(tgt), .acc_out(acc), .opa_out(opa));
  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    {htr, hw, ha} <= {2'h2, w, a};
    do @(posedge clk); while (hro !== 1'b1);
    {htr, hwd} <= {2'h0, d};
    do @(posedge clk); while (hro !== 1'b1);
    q = hrd;
  endtask
  task automatic go(input logic [2:0] k, input logic [9:0] t, input logic [7:0] a, d);
    pcs_dec_model_inst.op(k, t, a, d[5:0]);
    #1 chk("pc", pc, fa);
  endtask
  task automatic end_sim;
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  initial begin
    {nrst, htr, hw, ha, hwd} = 68'h0;
    pc = 13'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    #1 chk("pc", 0, fa);
    bus(0, 32'h20, 0);
    chk("state", 0, q);
    bus(0, 32'h3c, 0);
    chk("unmapped", 0, q);
    repeat (3) begin
      pc++;
      go(0, 0, 0, 1);
    end
    for (int p = 0; p < 8; p++) begin
      bus(1, 32'hc, p << 5);
      bus(0, 32'hc, 0);
      chk("page", p << 5, q);
      chk("page_sel", p, pg);
      pc = {(p > 5 ? 3'h5 : 3'(p)), 10'h3ff};
      go(1, 10'h3ff, 0, 2);
    end
    pc = 13'h18ff;
    go(6, 0, 8'hff, 3);
    pc = 13'h16c0;
    go(1, 10'h2c0, 0, 4);
    pc = 13'h165a;
    go(7, 0, 8'h5a, 5);
    bus(1, 32'hc, 32'h40);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) bus(1, 32'hc, 32'h80);
      st.push_back(pc + 13'h1);
      pc = {(i < 4 ? 3'h2 : 3'h4), 10'(i * 9)};
      go(2, 10'(i * 9), 0, 6);
      chk("level", i + 1, lvl);
    end
    for (int i = 0; i < 8; i++) begin
      pc = st.pop_back();
      go(3'(3 + i % 3), 0, 0, 7);
    end
    chk("page_sel", 4, pg);
    bus(1, 32'h8, 32'h3c);
    #1 chk("pc", 13'h123c, fa);
    bus(0, 32'h8, 0);
    chk("pc_reg", 32'h3c, q);
    bus(1, 32'h10, 32'hc4);
    bus(0, 32'h0, 0);
    chk("window", 32'hc4, q);
    chk("ptr", 8'hc4, ptr);
    chk("resp", 0, hrs);
    pcs_dec_model_inst.op(0, 0, 0, 6'h0);
    #1 chk("eff", 6'h04, eff);
    pcs_dec_model_inst.op(2, 10'h5, 0, 6'h15);
    #1 chk("eff", 6'h15, eff);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1 chk("pc", 0, fa);
    chk("level", 0, lvl);
    end_sim();
  end
endmodule
